//--- rtl/fpt_tracker.sv
// Tracker of floating-point register set use: modified and disabled flags.
// Assumes accesses and bus come from logic on ref_clk; priv marks kernel privilege.
// Summary of operation
// - Lower and higher FP sets tracked separately.
// - Writes to an enabled set set the matching modified flag.
// - User code reads and clears modified flags.
// - Only privileged code touches disabled flags.
// - Disabled set access raises the fault.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fpt_tracker
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register access from the execution pipeline.
  input wire fpt_pkg::fpt_access_t acc,
  output logic fault,
  output logic wr_commit,
  // Register port.
  input wire fpt_pkg::fpt_bus_t bus,
  output logic [31:0] rdata,
  // Flags and interrupt.
  output logic fp_low_modified,
  output logic fp_high_modified,
  output logic fp_low_disabled,
  output logic fp_high_disabled,
  output logic irq
);
  import fpt_pkg::*;

  // Two sets are tracked: index 0 is the lower set, index 1 the higher set.
  localparam int unsigned set_count = 2;

  // Access decode.
  logic acc_use;
  logic acc_write;
  logic [1:0] in_set;
  wire [1:0] set_hit;
  wire [1:0] set_write;
  logic hit;
  logic commit;

  // Access result group.
  logic next_fault;
  logic next_wr_commit;

  // Register port decode.
  logic wr_modified;
  logic wr_disabled;
  logic wr_status;
  logic wr_mask;
  logic rd_modified;
  logic rd_disabled;
  logic rd_status;
  logic rd_mask;

  // Flag group.
  logic [1:0] modified;
  logic [1:0] disabled;
  logic [1:0] next_modified;
  logic [1:0] next_disabled;

  // Event group.
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] next_status;
  logic [2:0] next_mask;
  logic next_irq;

  // Read group.
  logic [31:0] next_rdata;

  // Accesses come from pipeline logic on this clock, so no synchroniser is needed.
  always_comb
  begin
    acc_use = acc.valid && (acc.rd || acc.wr);
    acc_write = acc.valid && acc.wr;
  end

  // FR0 and FR1 are constants and belong to neither set.
  always_comb
  begin
    in_set[fpt_bit_low] = (acc.num >= fpt_low_first) && (acc.num < fpt_high_first);
    in_set[fpt_bit_high] = acc.num >= fpt_high_first;
  end

  // The same refusal and write logic serves each set.
  genvar s;
  generate
    for (s = 0; s < set_count; s = s + 1)
    begin : g_set
      assign set_hit[s] = acc_use && in_set[s] && disabled[s];
      assign set_write[s] = acc_write && in_set[s] && !disabled[s];
    end
  endgenerate

  // Every access to a disabled set faults, not only the first one; the handler
  // clears the flag once the set is saved, which keeps this logic stateless.
  // A faulting access commits nothing, so neither a register nor a flag changes.
  always_comb
  begin
    hit = |set_hit;
    commit = |set_write;
    next_fault = hit;
    next_wr_commit = commit;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fault <= 1'h0;
      wr_commit <= 1'h0;
    end
    else
    begin
      fault <= next_fault;
      wr_commit <= next_wr_commit;
    end
  end

  // A disabled-flag write without kernel privilege is dropped, not an error.
  // Unmapped offsets ignore writes and read as zero.
  always_comb
  begin
    wr_modified = 1'h0;
    wr_disabled = 1'h0;
    wr_status = 1'h0;
    wr_mask = 1'h0;
    if (bus.wr)
    begin
      case (bus.addr)
        fpt_off_modified:
        begin
          wr_modified = 1'h1;
        end
        fpt_off_disabled:
        begin
          wr_disabled = bus.priv;
        end
        fpt_off_status:
        begin
          wr_status = 1'h1;
        end
        fpt_off_mask:
        begin
          wr_mask = 1'h1;
        end
        default:
        begin
          wr_mask = 1'h0;
        end
      endcase
    end
  end

  // Reads of the disabled flags without kernel privilege return zero.
  always_comb
  begin
    rd_modified = 1'h0;
    rd_disabled = 1'h0;
    rd_status = 1'h0;
    rd_mask = 1'h0;
    if (bus.rd)
    begin
      case (bus.addr)
        fpt_off_modified:
        begin
          rd_modified = 1'h1;
        end
        fpt_off_disabled:
        begin
          rd_disabled = bus.priv;
        end
        fpt_off_status:
        begin
          rd_status = 1'h1;
        end
        fpt_off_mask:
        begin
          rd_mask = 1'h1;
        end
        default:
        begin
          rd_mask = 1'h0;
        end
      endcase
    end
  end

  // User code may set a modified flag as well as clear it.
  // The hardware set is applied last so that it wins over a same-cycle clear.
  always_comb
  begin
    next_modified = modified;
    next_disabled = disabled;
    if (wr_modified)
    begin
      next_modified = bus.wdata[1:0];
    end
    if (wr_disabled)
    begin
      next_disabled = bus.wdata[1:0];
    end
    next_modified = next_modified | set_write;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      modified <= fpt_rst_modified;
      disabled <= fpt_rst_disabled;
    end
    else
    begin
      modified <= next_modified;
      disabled <= next_disabled;
    end
  end

  // Status bits are sticky; software clears them by writing ones.
  always_comb
  begin
    next_status = status;
    next_mask = mask;
    if (wr_status)
    begin
      next_status = status & ~bus.wdata[2:0];
    end
    if (wr_mask)
    begin
      next_mask = bus.wdata[2:0];
    end
    next_status[fpt_bit_low] = next_status[fpt_bit_low] | set_write[fpt_bit_low];
    next_status[fpt_bit_high] = next_status[fpt_bit_high] | set_write[fpt_bit_high];
    next_status[fpt_bit_fault] = next_status[fpt_bit_fault] | hit;
    next_irq = |(next_status & next_mask);
  end

  // The interrupt is registered from the next status so it rises with the bit.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      status <= fpt_rst_status;
      mask <= fpt_rst_mask;
      irq <= 1'h0;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  // Read data stands for the one cycle after the read strobe and is zero otherwise.
  always_comb
  begin
    next_rdata = 32'h0;
    if (rd_modified)
    begin
      next_rdata = {30'h0, modified};
    end
    if (rd_disabled)
    begin
      next_rdata = {30'h0, disabled};
    end
    if (rd_status)
    begin
      next_rdata = {29'h0, status};
    end
    if (rd_mask)
    begin
      next_rdata = {29'h0, mask};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h0;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Flag outputs are the flip-flops themselves.
  always_comb
  begin
    fp_low_modified = modified[fpt_bit_low];
    fp_high_modified = modified[fpt_bit_high];
    fp_low_disabled = disabled[fpt_bit_low];
    fp_high_disabled = disabled[fpt_bit_high];
  end
endmodule : fpt_tracker
`default_nettype wire

//--- pkg/fpt_pkg.sv
// Package for the floating-point set modify/disable tracker.
// Assumes a single core clock domain and a plain register port.
package fpt_pkg;
  localparam int unsigned fpt_addr_w = 4;
  localparam int unsigned fpt_reg_w = 7;
  localparam logic [6:0] fpt_low_first = 7'h02;
  localparam logic [6:0] fpt_high_first = 7'h20;
  // Register offsets (byte addresses).
  localparam logic [3:0] fpt_off_modified = 4'h0;
  localparam logic [3:0] fpt_off_disabled = 4'h4;
  localparam logic [3:0] fpt_off_status = 4'h8;
  localparam logic [3:0] fpt_off_mask = 4'hc;
  // Field positions.
  localparam int unsigned fpt_bit_low = 0;
  localparam int unsigned fpt_bit_high = 1;
  localparam int unsigned fpt_bit_fault = 2;
  // Reset values.
  localparam logic [1:0] fpt_rst_modified = 2'h0;
  localparam logic [1:0] fpt_rst_disabled = 2'h0;
  localparam logic [2:0] fpt_rst_status = 3'h0;
  localparam logic [2:0] fpt_rst_mask = 3'h0;

  typedef struct packed {
    logic valid;
    logic rd;
    logic wr;
    logic [6:0] num;
  } fpt_access_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic priv;
    logic [3:0] addr;
    logic [31:0] wdata;
  } fpt_bus_t;
endpackage : fpt_pkg

//--- tb/fpt_chk_sva.sv
// Checker for the floating-point set tracker ports.
// Assumes it is bound to fpt_tracker and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module fpt_chk
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fpt_pkg::fpt_access_t acc,
  input wire logic fault,
  input wire logic wr_commit,
  input wire fpt_pkg::fpt_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic fp_low_modified,
  input wire logic fp_high_modified,
  input wire logic fp_low_disabled,
  input wire logic fp_high_disabled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire lw = acc.valid && acc.wr && acc.num > 1 && acc.num < 32;
  wire hw = acc.valid && acc.wr && acc.num > 31;
  low_mod_a: assert property (lw && !fp_low_disabled |=> fp_low_modified)
    else $error("low flag");
  high_mod_a: assert property (hw && !fp_high_disabled |=> fp_high_modified)
    else $error("high flag");
  high_fault_a: assert property (hw && fp_high_disabled |=> fault && !wr_commit)
    else $error("no fault");
  low_keep_a: assert property (lw && fp_low_disabled && !bus.wr |=> $stable(fp_low_modified))
    else $error("flag moved");
  user_dis_a: assert property (bus.wr && !bus.priv && bus.addr == 4'h4 |=>
    $stable({fp_low_disabled, fp_high_disabled})) else $error("user change");
  mod_read_a: assert property (bus.rd && bus.addr == 4'h0 |=>
    rdata[1:0] == $past({fp_high_modified, fp_low_modified})) else $error("read");
  const_reg_a: assert property (acc.valid && acc.num < 2 |=> !fault && !wr_commit)
    else $error("constant register touched");
  low_fault_a: assert property (lw && fp_low_disabled |=> fault && !wr_commit)
    else $error("no low fault");
  user_read_a: assert property (bus.rd && !bus.priv && bus.addr == fpt_pkg::fpt_off_disabled
    |=> rdata == 32'h0) else $error("user read");
endmodule : fpt_chk
bind fpt_tracker fpt_chk chk
(
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .acc(acc),
  .fault(fault),
  .wr_commit(wr_commit),
  .bus(bus),
  .rdata(rdata),
  .fp_low_modified(fp_low_modified),
  .fp_high_modified(fp_high_modified),
  .fp_low_disabled(fp_low_disabled),
  .fp_high_disabled(fp_high_disabled)
);
`default_nettype wire

//--- tb/fpt_tracker_tb.sv
// Bench for the floating-point set tracker.
// Assumes the checker is bound to the design.
`timescale 1ns/100ps
`default_nettype none
module fpt_tracker_tb;
  import fpt_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  fpt_access_t acc = '0;
  fpt_bus_t bus = '0;
  logic fault, wr_commit, fp_low_modified, fp_high_modified;
  logic fp_low_disabled, fp_high_disabled, irq;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int checks = 0;
  fpt_tracker dut
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .acc(acc),
    .fault(fault),
    .wr_commit(wr_commit),
    .bus(bus),
    .rdata(rdata),
    .fp_low_modified(fp_low_modified),
    .fp_high_modified(fp_high_modified),
    .fp_low_disabled(fp_low_disabled),
    .fp_high_disabled(fp_high_disabled),
    .irq(irq)
  );
  always #25 ref_clk = ~ref_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t bad value", $time);
    end
  endtask : chk
  task wr(input logic p, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk) bus <= {2'h2, p, a, d};
    @(posedge ref_clk) bus <= '0;
    #1;
  endtask : wr
  task rdk(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk) bus <= {3'h2, a, 32'h0};
    @(posedge ref_clk) bus <= '0;
    #1;
    chk(rdata, e);
  endtask : rdk
  task ac(input logic [1:0] k, input logic [6:0] n);
    @(posedge ref_clk) acc <= {1'h1, k, n};
    @(posedge ref_clk) acc <= '0;
    #1;
  endtask : ac
  task t_mod;
    ac(2'h1, 7'h02);
    chk({wr_commit, fp_low_modified, fp_high_modified}, 3'h6);
    ac(2'h1, 7'h20);
    chk(fp_high_modified, 1'h1);
    wr(1'h0, 4'h0, 32'h1);
    rdk(4'h0, 32'h1);
  endtask : t_mod
  task t_dis;
    wr(1'h0, 4'h4, 32'h3);
    chk({fp_low_disabled, fp_high_disabled}, 2'h0);
    wr(1'h1, 4'h4, 32'h2);
    ac(2'h1, 7'h20);
    chk({fault, wr_commit, fp_high_modified}, 3'h4);
    ac(2'h2, 7'h7f);
    chk(fault, 1'h1);
    ac(2'h2, 7'h1f);
    chk(fault, 1'h0);
    wr(1'h1, 4'hc, 32'h4);
    rdk(4'h8, 32'h7);
    chk(irq, 1'h1);
    wr(1'h1, 4'h8, 32'h7);
    @(posedge ref_clk) #1;
    chk(irq, 1'h0);
  endtask : t_dis
  // Constant registers, lower-set refusal, user read of the disabled flags, mask gating.
  task t_low;
    ac(2'h1, 7'h01);
    chk({fault, wr_commit, fp_low_modified, fp_high_modified}, 4'h2);
    wr(1'h0, 4'h0, 32'h0);
    wr(1'h1, 4'h4, 32'h1);
    rdk(4'h4, 32'h0);
    ac(2'h1, 7'h05);
    chk({fault, wr_commit, fp_low_modified}, 3'h4);
    chk(irq, 1'h1);
    wr(1'h1, 4'hc, 32'h0);
    chk(irq, 1'h0);
  endtask : t_low
  // One exit for both the normal end and the watchdog.
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_mod;
    t_dis;
    t_low;
    stop_test;
  end
  // The tests take about 60 cycles; 400 cycles leaves a wide margin.
  initial
  begin
    #20000;
    n_mismatch++;
    stop_test;
  end
endmodule : fpt_tracker_tb
`default_nettype wire
